// ---- hw/fifo_flag_pkg.sv ----
// Constants, field layouts and carrier types of the pin-sampled dual-clock FIFO
// Notes on behaviour
// R1 - Reset works with both clocks still running
// R2 - After reset outputs low, or released by enable
// R3 - Load pin high at reset: second write enable
// R4 - Load pin low at reset: offset load enable
// R5 - Full flag may release one write edge late
// R6 - Empty flag may release one read edge late
// R7 - Almost-empty may update one read edge late
// R8 - Read at almost-empty assert leaves n words
// R9 - Write at almost-full assert leaves depth-m words
// R10 - Dual mode: store on enable low, second high
// R11 - Writes ignored while full; full on write edges
// R12 - Reads ignored while empty; empty on read edges
// R13 - Load mode fills four offset registers, wraps
// R14 - Flags from synchronised pointer difference
package fifo_flag_pkg;
   localparam int DATA_W = 9;
   localparam int OFS_W = 8;
   localparam int BUS_AW = 4;
   localparam int BUS_DW = 32;
   localparam int SEL_W = 2;
   localparam int SYNC_W = 8 + DATA_W;

   // Register offsets
   localparam logic [BUS_AW-1:0] REG_EVENT_STATUS = 4'h0;
   localparam logic [BUS_AW-1:0] REG_EVENT_MASK = 4'h4;
   localparam logic [BUS_AW-1:0] REG_FLAG_STATE = 4'h8;
   localparam logic [BUS_AW-1:0] REG_FILL_LEVEL = 4'hc;

   // Event bit positions
   localparam int EV_W = 4;
   localparam int EV_OVERFLOW = 0;
   localparam int EV_UNDERFLOW = 1;
   localparam int EV_FULL = 2;
   localparam int EV_EMPTY = 3;

   // Flag state field positions
   localparam int FS_FULL_LOW = 0;
   localparam int FS_AFULL_LOW = 1;
   localparam int FS_AEMPTY_LOW = 2;
   localparam int FS_EMPTY_LOW = 3;
   localparam int FS_LOAD_MODE = 4;
   localparam int FS_IN_RESET = 5;

   // Reset values and selector step
   localparam logic [OFS_W-1:0] OFS_DEFAULT_LO = 8'h07;
   localparam logic [OFS_W-1:0] OFS_DEFAULT_HI = 8'h00;
   localparam logic [EV_W-1:0] EV_MASK_RESET = 4'h0;
   localparam logic [SEL_W-1:0] SEL_FIRST = 2'h0;
   localparam logic [SEL_W-1:0] SEL_STEP = 2'h1;

   // Offset register order
   localparam logic [SEL_W-1:0] SEL_EMPTY_LO = 2'h0;
   localparam logic [SEL_W-1:0] SEL_EMPTY_HI = 2'h1;
   localparam logic [SEL_W-1:0] SEL_FULL_LO = 2'h2;
   localparam logic [SEL_W-1:0] SEL_FULL_HI = 2'h3;

   typedef struct packed {
      logic reset_input_low;
      logic write_clock;
      logic read_clock;
      logic primary_write_enable_low;
      logic second_write_or_offset_load;
      logic read_enable_a_low;
      logic read_enable_b_low;
      logic output_enable_low;
      logic [DATA_W-1:0] data;
   } pins_type;

   typedef struct packed {
      logic full_flag_low;
      logic almost_full_flag_low;
      logic almost_empty_flag_low;
      logic empty_flag_low;
   } flags_type;

   localparam flags_type FLAGS_RESET = '{full_flag_low: 1'b1, almost_full_flag_low: 1'b1,
                                         almost_empty_flag_low: 1'b0, empty_flag_low: 1'b0};
endpackage : fifo_flag_pkg

// ---- hw/fifo_flag_core.sv ----
// Pin-sampled dual-clock FIFO with programmable flags and event interrupt
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
module fifo_flag_core
   import fifo_flag_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic reset_input_low_in,
   input wire logic write_clock_in,
   input wire logic read_clock_in,
   input wire logic primary_write_enable_low_in,
   input wire logic second_write_or_offset_load_in,
   input wire logic read_enable_a_low_in,
   input wire logic read_enable_b_low_in,
   input wire logic output_enable_low_in,
   input wire logic [DATA_W-1:0] data_in,
   input wire logic [BUS_AW-1:0] bus_addr_in,
   input wire logic [BUS_DW-1:0] bus_wdata_in,
   input wire logic bus_write_in,
   input wire logic bus_read_in,
   output logic [BUS_DW-1:0] bus_rdata_out,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe_out,
   output logic full_flag_low_out,
   output logic almost_full_flag_low_out,
   output logic almost_empty_flag_low_out,
   output logic empty_flag_low_out,
   output logic irq_out
);
   localparam int PTR_W = ADDR_W + 1;
   localparam int DEPTH = 1 << ADDR_W;
   localparam int CMP_W = 2 * OFS_W + 1;
   localparam logic [CMP_W-1:0] DEPTH_CMP = CMP_W'(DEPTH);

   ////////////////////////////////////////////////////////////////////////////
   // Pin sampling
   pins_type pins_raw;
   logic [SYNC_W-1:0] sync1_q, sync2_q, sync3_q, pin_q, pin_d, pin_prev_q;
   pins_type pin_now, pin_prev;

   assign pins_raw = '{reset_input_low: reset_input_low_in, write_clock: write_clock_in,
                       read_clock: read_clock_in, primary_write_enable_low: primary_write_enable_low_in,
                       second_write_or_offset_load: second_write_or_offset_load_in,
                       read_enable_a_low: read_enable_a_low_in, read_enable_b_low: read_enable_b_low_in,
                       output_enable_low: output_enable_low_in, data: data_in};
   assign pin_now = pins_type'(pin_q);
   assign pin_prev = pins_type'(pin_prev_q);

   always_comb begin
      // Accept a bit only when second and third stages agree
      pin_d = (sync2_q & sync3_q) | (pin_q & (sync2_q | sync3_q));
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         sync1_q <= '0;
         sync2_q <= '0;
         sync3_q <= '0;
         pin_q <= '0;
         pin_prev_q <= '0;
      end else begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         pin_q <= pin_d;
         pin_prev_q <= pin_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // FIFO datapath and flags
   logic [DATA_W-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wptr_q, wptr_d, rptr_q, rptr_d, rsync_q, rsync_d, wsync_q, wsync_d;
   logic [PTR_W-1:0] cnt_w, cnt_r;
   logic [OFS_W-1:0] ofs_q [4];
   logic [OFS_W-1:0] ofs_d [4];
   logic [SEL_W-1:0] wsel_q, wsel_d, rsel_q, rsel_d;
   logic load_mode_q, load_mode_d;
   flags_type flags_q, flags_d;
   logic [DATA_W-1:0] dout_q, dout_d;
   logic oe_q, oe_d;
   logic dev_rst, wedge, redge, wr_req, rd_req, ld_active, wr_ok, rd_ok;
   logic ev_over, ev_under, ev_full, ev_empty;
   logic [CMP_W-1:0] n_val, m_val, sum_w, cnt_rx;

   assign dev_rst = !pin_now.reset_input_low;
   assign wedge = pin_now.write_clock && !pin_prev.write_clock;
   assign redge = pin_now.read_clock && !pin_prev.read_clock;
   assign ld_active = load_mode_q && !pin_now.second_write_or_offset_load;
   assign wr_req = wedge && !pin_now.primary_write_enable_low && pin_now.second_write_or_offset_load; // R10
   assign rd_req = redge && !pin_now.read_enable_a_low && !pin_now.read_enable_b_low;
   assign wr_ok = !dev_rst && wr_req && flags_q.full_flag_low; // R11
   assign rd_ok = !dev_rst && rd_req && !ld_active && flags_q.empty_flag_low; // R12
   assign n_val = CMP_W'({ofs_q[SEL_EMPTY_HI], ofs_q[SEL_EMPTY_LO]});
   assign m_val = CMP_W'({ofs_q[SEL_FULL_HI], ofs_q[SEL_FULL_LO]});

   always_comb begin
      wptr_d = wptr_q;
      rptr_d = rptr_q;
      rsync_d = rsync_q;
      wsync_d = wsync_q;
      ofs_d = ofs_q;
      wsel_d = wsel_q;
      rsel_d = rsel_q;
      load_mode_d = load_mode_q;
      flags_d = flags_q;
      dout_d = dout_q;
      oe_d = !pin_now.output_enable_low; // R2
      ev_over = 1'b0;
      ev_under = 1'b0;
      ev_full = 1'b0;
      ev_empty = 1'b0;
      cnt_w = '0;
      cnt_r = '0;
      sum_w = '0;
      cnt_rx = '0;
      if (dev_rst) begin
         // Clocks keep running; device state held at reset values
         wptr_d = '0; // R1
         rptr_d = '0;
         rsync_d = '0;
         wsync_d = '0;
         ofs_d = '{OFS_DEFAULT_LO, OFS_DEFAULT_HI, OFS_DEFAULT_LO, OFS_DEFAULT_HI};
         wsel_d = SEL_FIRST;
         rsel_d = SEL_FIRST;
         flags_d = FLAGS_RESET;
         dout_d = '0; // R2
         load_mode_d = !pin_now.second_write_or_offset_load; // R3 R4
      end else begin
         if (wedge) begin
            if (wr_ok) begin
               wptr_d = wptr_q + PTR_W'(1);
            end
            if (wr_req && !flags_q.full_flag_low) begin
               ev_over = 1'b1;
            end
            if (ld_active && !pin_now.primary_write_enable_low) begin
               ofs_d[wsel_q] = pin_now.data[OFS_W-1:0]; // R13
               wsel_d = wsel_q + SEL_STEP; // R13
            end
            // Read pointer seen only at a write edge
            rsync_d = rptr_q; // R14 R5
            cnt_w = wptr_d - rsync_d;
            sum_w = CMP_W'(cnt_w) + m_val;
            flags_d.full_flag_low = !(CMP_W'(cnt_w) == DEPTH_CMP); // R11 R14
            flags_d.almost_full_flag_low = !(sum_w >= DEPTH_CMP); // R9
            ev_full = flags_q.full_flag_low && !flags_d.full_flag_low;
         end
         if (redge) begin
            if (rd_ok) begin
               dout_d = mem[rptr_q[ADDR_W-1:0]];
               rptr_d = rptr_q + PTR_W'(1);
            end else if (rd_req && ld_active) begin
               dout_d = DATA_W'(ofs_q[rsel_q]);
               rsel_d = rsel_q + SEL_STEP;
            end else if (rd_req) begin
               ev_under = 1'b1;
            end
            // Write pointer seen only at a read edge
            wsync_d = wptr_q; // R14 R6 R7
            cnt_r = wsync_d - rptr_d;
            cnt_rx = CMP_W'(cnt_r);
            flags_d.empty_flag_low = (cnt_r != '0); // R12 R6
            flags_d.almost_empty_flag_low = (cnt_rx > n_val); // R7 R8
            ev_empty = flags_q.empty_flag_low && !flags_d.empty_flag_low;
         end
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         wptr_q <= '0;
         rptr_q <= '0;
         rsync_q <= '0;
         wsync_q <= '0;
         ofs_q <= '{OFS_DEFAULT_LO, OFS_DEFAULT_HI, OFS_DEFAULT_LO, OFS_DEFAULT_HI};
         wsel_q <= SEL_FIRST;
         rsel_q <= SEL_FIRST;
         load_mode_q <= 1'b0;
         flags_q <= FLAGS_RESET;
         dout_q <= '0;
         oe_q <= 1'b0;
      end else begin
         wptr_q <= wptr_d;
         rptr_q <= rptr_d;
         rsync_q <= rsync_d;
         wsync_q <= wsync_d;
         ofs_q <= ofs_d;
         wsel_q <= wsel_d;
         rsel_q <= rsel_d;
         load_mode_q <= load_mode_d;
         flags_q <= flags_d;
         dout_q <= dout_d;
         oe_q <= oe_d;
      end
   end

   // Storage array
   always_ff @(posedge clk_sys_in) begin
      if (wr_ok && !ld_active) begin
         mem[wptr_q[ADDR_W-1:0]] <= pin_now.data; // R10
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register port and interrupt
   logic [EV_W-1:0] ev_status_q, ev_status_d, ev_mask_q, ev_mask_d, ev_set;
   logic [BUS_DW-1:0] rdata_q, rdata_d;
   logic irq_q, irq_d;
   logic [PTR_W-1:0] level_w;

   assign level_w = wptr_q - rsync_q;

   always_comb begin
      ev_set = '0;
      ev_set[EV_OVERFLOW] = ev_over;
      ev_set[EV_UNDERFLOW] = ev_under;
      ev_set[EV_FULL] = ev_full;
      ev_set[EV_EMPTY] = ev_empty;
      ev_status_d = ev_status_q;
      ev_mask_d = ev_mask_q;
      rdata_d = '0;
      if (bus_write_in && bus_addr_in == REG_EVENT_STATUS) begin
         ev_status_d = ev_status_q & ~bus_wdata_in[EV_W-1:0];
      end
      if (bus_write_in && bus_addr_in == REG_EVENT_MASK) begin
         ev_mask_d = bus_wdata_in[EV_W-1:0];
      end
      // New events win over a clear in the same cycle
      ev_status_d = ev_status_d | ev_set;
      if (bus_read_in) begin
         unique case (bus_addr_in)
            REG_EVENT_STATUS: rdata_d = BUS_DW'(ev_status_q);
            REG_EVENT_MASK: rdata_d = BUS_DW'(ev_mask_q);
            REG_FLAG_STATE: begin
               rdata_d[FS_FULL_LOW] = flags_q.full_flag_low;
               rdata_d[FS_AFULL_LOW] = flags_q.almost_full_flag_low;
               rdata_d[FS_AEMPTY_LOW] = flags_q.almost_empty_flag_low;
               rdata_d[FS_EMPTY_LOW] = flags_q.empty_flag_low;
               rdata_d[FS_LOAD_MODE] = load_mode_q;
               rdata_d[FS_IN_RESET] = dev_rst;
            end
            REG_FILL_LEVEL: rdata_d = BUS_DW'(level_w);
            default: rdata_d = '0;
         endcase
      end
      irq_d = |(ev_status_d & ev_mask_d);
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         ev_status_q <= '0;
         ev_mask_q <= EV_MASK_RESET;
         rdata_q <= '0;
         irq_q <= 1'b0;
      end else begin
         ev_status_q <= ev_status_d;
         ev_mask_q <= ev_mask_d;
         rdata_q <= rdata_d;
         irq_q <= irq_d;
      end
   end

   assign bus_rdata_out = rdata_q;
   assign data_out = dout_q;
   assign data_oe_out = oe_q;
   assign full_flag_low_out = flags_q.full_flag_low;
   assign almost_full_flag_low_out = flags_q.almost_full_flag_low;
   assign almost_empty_flag_low_out = flags_q.almost_empty_flag_low;
   assign empty_flag_low_out = flags_q.empty_flag_low;
   assign irq_out = irq_q;
endmodule : fifo_flag_core

// ---- dv/fifo_flag_monitor.sv ----
// Checker of reset state, output enable, flag timing and register port
`timescale 1ns/10ps
module fifo_flag_monitor
   import fifo_flag_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic reset_input_low_in,
   input wire logic write_clock_in,
   input wire logic read_clock_in,
   input wire logic output_enable_low_in,
   input wire logic bus_read_in,
   input wire logic [BUS_DW-1:0] bus_rdata_out,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic data_oe_out,
   input wire logic full_flag_low_out,
   input wire logic almost_full_flag_low_out,
   input wire logic almost_empty_flag_low_out,
   input wire logic empty_flag_low_out
);
   logic [7:0] wc_q, rc_q, rs_q;
   logic w_rose, r_rose, dev_up;
   // Pin history, so a flag change can be traced to its own pin edge
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         wc_q <= '0;
         rc_q <= '0;
         rs_q <= '0;
      end else begin
         wc_q <= {wc_q[6:0], write_clock_in};
         rc_q <= {rc_q[6:0], read_clock_in};
         rs_q <= {rs_q[6:0], reset_input_low_in};
      end
   end
   assign w_rose = |(wc_q[6:2] & ~wc_q[7:3]);
   assign r_rose = |(rc_q[6:2] & ~rc_q[7:3]);
   assign dev_up = (&rs_q) && reset_input_low_in;
   ////////////////////////////////////////////////////////////////////////////////
   AST_DEV_RESET: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !reset_input_low_in [*7] |=> full_flag_low_out && almost_full_flag_low_out && !almost_empty_flag_low_out
         && !empty_flag_low_out && data_out == '0) else $error("flags or data not at reset state");
   AST_OE_OFF: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      output_enable_low_in [*8] |-> !data_oe_out) else $error("data driven while disabled");
   AST_OE_ON: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !output_enable_low_in [*8] |-> data_oe_out) else $error("data not driven while enabled");
   AST_FULL_EDGE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      dev_up && $changed(full_flag_low_out) |-> w_rose) else $error("full flag moved off write edge");
   AST_EMPTY_EDGE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      dev_up && $changed(empty_flag_low_out) |-> r_rose) else $error("empty flag moved off read edge");
   AST_AEMPTY_EDGE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      dev_up && $changed(almost_empty_flag_low_out) |-> r_rose) else $error("almost empty moved off read edge");
   AST_AFULL_EDGE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      dev_up && $changed(almost_full_flag_low_out) |-> w_rose) else $error("almost full moved off write edge");
   AST_FULL_AFULL: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !full_flag_low_out |-> !almost_full_flag_low_out) else $error("full without almost full");
   AST_EMPTY_AEMPTY: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !empty_flag_low_out |-> !almost_empty_flag_low_out) else $error("empty without almost empty");
   AST_RDATA_IDLE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !$past(bus_read_in) |-> bus_rdata_out == '0) else $error("read data outside its cycle");
endmodule : fifo_flag_monitor

bind fifo_flag_core fifo_flag_monitor #(.ADDR_W(ADDR_W)) u_fifo_flag_monitor (.clk_sys_in, .rst_in,
   .reset_input_low_in, .write_clock_in, .read_clock_in, .output_enable_low_in, .bus_read_in, .bus_rdata_out,
   .data_out, .data_oe_out, .full_flag_low_out, .almost_full_flag_low_out, .almost_empty_flag_low_out,
   .empty_flag_low_out);

// ---- dv/fifo_pin_agent.sv ----
// Far-side model: writer and reader logic driving the FIFO pins
`timescale 1ns/10ps
module fifo_pin_agent
   import fifo_flag_pkg::*;
(
   input wire logic clk_sys_in,
   output pins_type pins_out
);
   initial pins_out = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 9'h000};
   task automatic hold(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask : hold
   // Reset pulse, pin clocks toggling inside it
   task automatic dev_reset(input logic second);
      pins_out.second_write_or_offset_load <= second;
      pins_out.reset_input_low <= 1'b0;
      hold(3);
      pins_out.write_clock <= 1'b1;
      pins_out.read_clock <= 1'b1;
      hold(4);
      pins_out.write_clock <= 1'b0;
      pins_out.read_clock <= 1'b0;
      hold(4);
      pins_out.reset_input_low <= 1'b1;
      hold(8);
      pins_out.second_write_or_offset_load <= 1'b1;
      hold(8);
   endtask : dev_reset
   task automatic wr_edge(input logic wen_low, input logic second, input logic [DATA_W-1:0] d);
      pins_out.primary_write_enable_low <= wen_low;
      pins_out.second_write_or_offset_load <= second;
      pins_out.data <= d;
      hold(4);
      pins_out.write_clock <= 1'b1;
      hold(4);
      pins_out.write_clock <= 1'b0;
      pins_out.primary_write_enable_low <= 1'b1;
      pins_out.second_write_or_offset_load <= 1'b1;
      pins_out.data <= ~d;
      hold(4);
   endtask : wr_edge
   // Read clock pulse with each read enable driven on its own
   task automatic rd_pins(input logic a_low, input logic b_low, input logic second);
      pins_out.read_enable_a_low <= a_low;
      pins_out.read_enable_b_low <= b_low;
      pins_out.second_write_or_offset_load <= second;
      hold(4);
      pins_out.read_clock <= 1'b1;
      hold(4);
      pins_out.read_clock <= 1'b0;
      pins_out.read_enable_a_low <= 1'b1;
      pins_out.read_enable_b_low <= 1'b1;
      pins_out.second_write_or_offset_load <= 1'b1;
      hold(4);
   endtask : rd_pins
   task automatic rd_edge(input logic en, input logic second);
      rd_pins(!en, !en, second);
   endtask : rd_edge
   task automatic set_oe(input logic v);
      pins_out.output_enable_low <= v;
   endtask : set_oe
endmodule : fifo_pin_agent

// ---- dv/testbench.sv ----
// Self-checking bench of the pin-sampled dual-clock FIFO
`timescale 1ns/10ps
module testbench;
   import fifo_flag_pkg::*;
   localparam int ADDR_W = 4;
   localparam int DEPTH = 2 ** ADDR_W;
   localparam int OFS = int'(OFS_DEFAULT_LO);
   logic clk_sys_in = 1'b0;
   logic rst_in;
   logic [BUS_AW-1:0] bus_addr_in;
   logic [BUS_DW-1:0] bus_wdata_in;
   logic bus_write_in;
   logic bus_read_in;
   logic [BUS_DW-1:0] bus_rdata_out, rd;
   logic [DATA_W-1:0] data_out;
   logic data_oe_out, irq_out;
   flags_type flg;
   pins_type pins;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   always #10 clk_sys_in = ~clk_sys_in;
   fifo_pin_agent u_fifo_pin_agent (.clk_sys_in, .pins_out(pins));
   fifo_flag_core #(.ADDR_W(ADDR_W)) u_fifo_flag_core (.clk_sys_in, .rst_in,
      .reset_input_low_in(pins.reset_input_low), .write_clock_in(pins.write_clock), .read_clock_in(pins.read_clock),
      .primary_write_enable_low_in(pins.primary_write_enable_low),
      .second_write_or_offset_load_in(pins.second_write_or_offset_load),
      .read_enable_a_low_in(pins.read_enable_a_low), .read_enable_b_low_in(pins.read_enable_b_low),
      .output_enable_low_in(pins.output_enable_low), .data_in(pins.data), .bus_addr_in, .bus_wdata_in,
      .bus_write_in, .bus_read_in, .bus_rdata_out, .data_out, .data_oe_out,
      .full_flag_low_out(flg.full_flag_low), .almost_full_flag_low_out(flg.almost_full_flag_low),
      .almost_empty_flag_low_out(flg.almost_empty_flag_low), .empty_flag_low_out(flg.empty_flag_low), .irq_out);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   always @(posedge clk_sys_in) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         num_errors++;
         test_done();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic bus_wr(input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] d);
      bus_addr_in <= a;
      bus_wdata_in <= d;
      bus_write_in <= 1'b1;
      @(posedge clk_sys_in);
      bus_write_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask : bus_wr
   task automatic bus_rd(input logic [BUS_AW-1:0] a, output logic [BUS_DW-1:0] d);
      bus_addr_in <= a;
      bus_read_in <= 1'b1;
      @(posedge clk_sys_in);
      bus_read_in <= 1'b0;
      #1 d = bus_rdata_out;
      @(posedge clk_sys_in);
   endtask : bus_rd
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_oe();
      u_fifo_pin_agent.dev_reset(1'b1);
      bus_rd(REG_FLAG_STATE, rd);
      check("flag state", rd & 32'h3f, 32'h03);
      check("data", 32'(data_out), 32'h0);
      u_fifo_pin_agent.set_oe(1'b1);
      u_fifo_pin_agent.hold(8);
      check("oe off", 32'(data_oe_out), 32'h0);
      u_fifo_pin_agent.set_oe(1'b0);
      u_fifo_pin_agent.hold(8);
      check("oe on", 32'(data_oe_out), 32'h1);
      bus_rd(4'h2, rd);
      check("unmapped", rd, 32'h0);
   endtask : t_reset_oe
   task automatic t_fill();
      for (int k = 1; k <= DEPTH; k++) begin
         u_fifo_pin_agent.wr_edge(1'b0, 1'b1, {1'b1, 8'(k)});
         check("afull", 32'(flg.almost_full_flag_low), 32'(k + OFS < DEPTH));
         check("full", 32'(flg.full_flag_low), 32'(k < DEPTH));
      end
      u_fifo_pin_agent.wr_edge(1'b0, 1'b1, 9'h055);
      bus_rd(REG_FILL_LEVEL, rd);
      check("level", rd, 32'(DEPTH));
      bus_wr(REG_EVENT_MASK, 32'h1 << EV_OVERFLOW);
      u_fifo_pin_agent.hold(2);
      check("irq set", 32'(irq_out), 32'h1);
      bus_wr(REG_EVENT_STATUS, 32'h1 << EV_OVERFLOW);
      u_fifo_pin_agent.hold(2);
      check("irq clear", 32'(irq_out), 32'h0);
      bus_wr(REG_EVENT_MASK, 32'h0);
      u_fifo_pin_agent.rd_edge(1'b0, 1'b1);
      u_fifo_pin_agent.rd_edge(1'b0, 1'b1);
      for (int i = 1; i <= DEPTH; i++) begin
         u_fifo_pin_agent.rd_edge(1'b1, 1'b1);
         if (i == 1) check("full late", 32'(flg.full_flag_low), 32'h0);
         check("data", 32'(data_out), 32'({1'b1, 8'(i)}));
         check("empty", 32'(flg.empty_flag_low), 32'(DEPTH - i != 0));
         check("aempty", 32'(flg.almost_empty_flag_low), 32'(DEPTH - i > OFS));
      end
      u_fifo_pin_agent.wr_edge(1'b1, 1'b1, 9'h0aa);
      check("full back", 32'(flg.full_flag_low & flg.almost_full_flag_low), 32'h1);
      u_fifo_pin_agent.rd_edge(1'b1, 1'b1);
      check("no read", 32'(data_out), 32'({1'b1, 8'(DEPTH)}));
      bus_rd(REG_EVENT_STATUS, rd);
      check("underflow", 32'(rd[EV_UNDERFLOW]), 32'h1);
   endtask : t_fill
   task automatic t_load();
      logic [7:0] ofs [4] = '{8'h05, 8'h00, 8'h03, 8'h00};
      u_fifo_pin_agent.dev_reset(1'b0);
      bus_rd(REG_FLAG_STATE, rd);
      check("load mode", 32'(rd[FS_LOAD_MODE]), 32'h1);
      for (int i = 0; i < 4; i++) u_fifo_pin_agent.wr_edge(1'b0, 1'b0, {1'b0, ofs[i]});
      for (int i = 0; i < 4; i++) begin
         u_fifo_pin_agent.rd_edge(1'b1, 1'b0);
         check("offset", 32'(data_out[7:0]), 32'(ofs[i]));
      end
      u_fifo_pin_agent.wr_edge(1'b0, 1'b0, 9'h002);
      u_fifo_pin_agent.rd_edge(1'b1, 1'b0);
      check("offset wrap", 32'(data_out[7:0]), 32'h02);
      for (int i = 0; i < 3; i++) u_fifo_pin_agent.wr_edge(1'b0, 1'b1, 9'(i));
      u_fifo_pin_agent.rd_edge(1'b0, 1'b1);
      u_fifo_pin_agent.rd_edge(1'b0, 1'b1);
      check("aempty n", 32'(flg.almost_empty_flag_low), 32'h1);
      u_fifo_pin_agent.rd_pins(1'b0, 1'b1, 1'b1);
      check("only enable a", 32'(data_out), 32'h002);
      u_fifo_pin_agent.rd_pins(1'b1, 1'b0, 1'b1);
      check("only enable b", 32'(data_out), 32'h002);
      u_fifo_pin_agent.rd_edge(1'b1, 1'b1);
      check("first word", 32'(data_out), 32'h000);
   endtask : t_load
   initial begin
      rst_in = 1'b1;
      bus_addr_in = '0;
      bus_wdata_in = '0;
      bus_write_in = 1'b0;
      bus_read_in = 1'b0;
      repeat (16) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      @(posedge clk_sys_in);
      t_reset_oe();
      t_fill();
      t_load();
      test_done();
   end
endmodule : testbench
